// file: hdl/dcf_pkg.sv
package dcf_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Buffer geometry defaults.
    localparam int DCF_DEPTH_DEF = 8192;
    localparam int DCF_WIDTH_DEF = 18;
    localparam int DCF_DEPTH_MIN = 2048;

    ////////////////////////////////////////////////////////////////////////////////
    // Register map, byte addresses on the Wishbone slave.
    localparam int           DCF_ADR_W          = 4;
    localparam logic [3:0]   DCF_ADDR_EMPTY_OFF = 4'h0;
    localparam logic [3:0]   DCF_ADDR_FULL_OFF  = 4'h4;
    localparam logic [3:0]   DCF_ADDR_STATUS    = 4'h8;
    localparam logic [3:0]   DCF_ADDR_LEVEL     = 4'hC;

    // Status register bit positions.
    localparam int DCF_ST_EMPTY_PIN = 0;
    localparam int DCF_ST_FULL_PIN  = 1;
    localparam int DCF_ST_AE_N      = 2;
    localparam int DCF_ST_HF_N      = 3;
    localparam int DCF_ST_AF_N      = 4;
    localparam int DCF_ST_FT_MODE   = 5;
    localparam int DCF_ST_SERIAL    = 6;

    ////////////////////////////////////////////////////////////////////////////////
    // Offset defaults chosen by the load pin at reset.
    localparam logic [15:0] DCF_OFF_SERIAL_DEF   = 16'h03FF;
    localparam logic [15:0] DCF_OFF_PARALLEL_DEF = 16'h007F;

    // Register stages on the flag paths and the fall-through latency.
    localparam int DCF_SYNC_STAGES   = 2;
    localparam int DCF_FT_LATENCY    = 3;

    ////////////////////////////////////////////////////////////////////////////////
    // Timing mode picked at reset.
    typedef enum logic [0:0] {
        DCF_MODE_STANDARD     = 1'b0,
        DCF_MODE_FALL_THROUGH = 1'b1
    } dcf_mode_t;

endpackage

// file: hdl/dcf_fifo.sv
// Chosen here: the placing of the registers and the Wishbone register port.
`timescale 1ns/1ns
// Contract
// - Mode pin sampled during reset: low standard flags, high fall-through flags.
// - Fall-through: first word reaches outputs three edges after write, unrequested.
// - Write enable low stores one word per rising edge in both modes.
// - Standard: empty flag goes high after first word written.
// - Standard: almost-empty goes high at n plus one words.
// - Standard: half-full goes low when level passes half depth.
// - Standard: almost-full goes low at depth minus m words.
// - Standard: full flag low and writes blocked at depth words.
// - Standard: reading releases full, then almost-full and half-full as level drops.
// - Standard: almost-empty goes low when reads bring level to n.
// - Standard: last read drives empty low; read enable ignored while empty.
// - Empty and full pass two stages; output-ready three, input-ready two.
// - Fall-through: output-ready goes low after the first word is written.
// - Fall-through: almost-empty goes high at n plus two words.
// - Fall-through: half-full goes low when level passes half depth plus one.
// - Fall-through: almost-full goes low at depth plus one minus m words.
// - Fall-through: output register adds one word; input-ready blocks at depth plus one.
// - Fall-through: almost-empty goes low when reads bring level to n plus one.
// - Fall-through: last read drives output-ready high; read enable ignored while empty.
// - Load pin high at reset: serial loading, both offsets default 3FF.
// - Load pin low at reset: parallel loading, both offsets default 07F.
// - Offsets readable only in parallel method; writable any time after reset.
module dcf_fifo
    import dcf_pkg::*;
#(
    parameter int DEPTH = DCF_DEPTH_DEF,
    parameter int WIDTH = DCF_WIDTH_DEF
) (
    input  wire logic                 clk,                    // System clock, 100 MHz.
    input  wire logic                 rst_b,                  // Master reset, synchronous, active low.
    input  wire logic                 wb_cyc_i,               // Wishbone cycle.
    input  wire logic                 wb_stb_i,               // Wishbone strobe.
    input  wire logic                 wb_we_i,                // Wishbone write enable.
    input  wire logic [DCF_ADR_W-1:0] wb_adr_i,               // Wishbone byte address.
    input  wire logic [3:0]           wb_sel_i,               // Wishbone byte lanes.
    input  wire logic [31:0]          wb_dat_i,               // Wishbone write data.
    output logic      [31:0]          wb_dat_o,               // Wishbone read data.
    output logic                      wb_ack_o,               // Wishbone acknowledge.
    input  wire logic                 write_en_n,             // Write enable, active low.
    input  wire logic [WIDTH-1:0]     data_in,                // Input word.
    input  wire logic                 read_en_n,              // Read enable, active low.
    output logic      [WIDTH-1:0]     data_out,               // Output word.
    input  wire logic                 mode_select_serial_in,  // Mode strap pin.
    input  wire logic                 offset_load_n,          // Offset method strap pin.
    output logic                      empty_flag_n,           // Empty flag, or output-ready in fall-through.
    output logic                      full_flag_n,            // Full flag, or input-ready in fall-through.
    output logic                      almost_empty_flag_n,    // Almost-empty flag.
    output logic                      almost_full_flag_n,     // Almost-full flag.
    output logic                      half_full_flag_n,       // Half-full flag.
    output logic                      fall_through_mode       // High when fall-through timing is active.
);

    ////////////////////////////////////////////////////////////////////////////////
    // Overview.
    //
    // Both ports run on clk, so the pointers need no gray code.
    // The flag pipes still keep the latency of a two-clock part.
    //
    // The array holds DEPTH words. In fall-through timing the
    // output register is one more word.
    //
    // Standard timing: the reader asks for every word.
    // data_out holds the last word popped between reads.
    //
    // Fall-through timing: the output register refills itself.
    // The head word waits on data_out before any request.
    //
    // Reads of an empty buffer are ignored in both timings.
    //
    // Writes while the array is full are dropped silently.
    //
    // Offsets may be rewritten at any time after reset.
    //
    // Limitation: the serial offset shift is not built.
    // Offsets go over the bus whatever method was strapped.
    //
    // Trade-off: registered flags lag one edge but never glitch.
    //
    // Each bus access is answered one edge after it is taken.

    ////////////////////////////////////////////////////////////////////////////////
    // Derived widths and elaboration checks.
    localparam int PTR_W = $clog2(DEPTH);
    localparam int CNT_W = $clog2(DEPTH + 2);
    localparam int OFF_W = PTR_W;

    localparam logic [CNT_W-1:0] DEPTH_C = CNT_W'(DEPTH);
    localparam logic [CNT_W-1:0] HALF_C  = CNT_W'(DEPTH / 2);

    // The serial default offset must fit and stay well below the depth.
    if (DEPTH < DCF_DEPTH_MIN || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
        $error("DEPTH must be a power of two of at least the minimum depth");
    end
    if (WIDTH < 1 || WIDTH > 32) begin : g_bad_width
        $error("WIDTH must lie between 1 and 32");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Whole control state of the block.
    typedef struct packed {
        // Strap synchronisers and latched settings.
        logic [DCF_SYNC_STAGES-1:0] mode_sync;
        logic [DCF_SYNC_STAGES-1:0] load_sync;
        dcf_mode_t                  mode;
        logic                       serial_load;

        // Flag offsets.
        logic [OFF_W-1:0]           empty_off;
        logic [OFF_W-1:0]           full_off;

        // Pointers and array count.
        logic [PTR_W-1:0]           wr_ptr;
        logic [PTR_W-1:0]           rd_ptr;
        logic [CNT_W-1:0]           mem_count;

        // Flag pipes and output register.
        logic [DCF_SYNC_STAGES-1:0] visible;
        logic [DCF_SYNC_STAGES-1:0] full_pipe;
        logic                       out_valid;
        logic [WIDTH-1:0]           data_out;

        // Level flags.
        logic                       ae_n;
        logic                       hf_n;
        logic                       af_n;

        // Bus reply.
        logic                       ack;
        logic [31:0]                rdata;
    } dcf_state_t;

    dcf_state_t        s;
    dcf_state_t        next_s;
    logic [WIDTH-1:0]  mem [DEPTH];
    logic              wr_ok;

    ////////////////////////////////////////////////////////////////////////////////
    // Helpers.

    // Byte-lane merge of a Wishbone write into a stored word.
    function automatic logic [31:0] dcf_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  sel);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // Widen an offset to the level width.
    function automatic logic [CNT_W-1:0] dcf_widen(input logic [OFF_W-1:0] v);
        return {{(CNT_W-OFF_W){1'b0}}, v};
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Next-state logic.
    always_comb begin
        logic              ft;
        logic [CNT_W-1:0]  level;
        logic [CNT_W-1:0]  ft_c;
        logic              rd_std;
        logic              take;
        logic              fetch;
        logic              pop;
        logic              access;
        logic [31:0]       merged;
        ft     = 1'b0;
        level  = '0;
        ft_c   = '0;
        rd_std = 1'b0;
        take   = 1'b0;
        fetch  = 1'b0;
        pop    = 1'b0;
        access = 1'b0;
        merged = '0;

        next_s = s;

        // Strap pins cross in through two flops before anything reads them.
        next_s.mode_sync = {s.mode_sync[0], mode_select_serial_in};
        next_s.load_sync = {s.load_sync[0], offset_load_n};

        ft    = (s.mode == DCF_MODE_FALL_THROUGH);
        ft_c  = {{(CNT_W-1){1'b0}}, ft};
        // The output register counts as a stored word in fall-through.
        level = s.mem_count + {{(CNT_W-1){1'b0}}, s.out_valid};

        // Writes stop once the array is full; the output register is the extra word.
        wr_ok = !write_en_n && (s.mem_count < DEPTH_C);

        // Standard reads wait until the empty flag shows data; the count guard stops underrun.
        rd_std = !ft && !read_en_n && s.visible[DCF_SYNC_STAGES-1]
                 && (s.mem_count != '0);
        take   = ft && !read_en_n && s.out_valid;
        // Fall-through refills the output register unrequested, after the visibility pipe.
        fetch  = ft && (!s.out_valid || take) && s.visible[DCF_SYNC_STAGES-1]
                 && (s.mem_count != '0);
        pop    = rd_std || fetch;

        if (pop) begin
            next_s.data_out = mem[s.rd_ptr];
            next_s.rd_ptr   = s.rd_ptr + PTR_W'(1);
        end

        if (fetch) begin
            next_s.out_valid = 1'b1;
        end else if (take) begin
            next_s.out_valid = 1'b0;
        end

        if (wr_ok) begin
            next_s.wr_ptr = s.wr_ptr + PTR_W'(1);
        end
        next_s.mem_count = s.mem_count + CNT_W'(wr_ok) - CNT_W'(pop);

        // Data presence and fullness pass two register stages before the pins see them.
        next_s.visible   = {s.visible[0], s.mem_count != '0};
        next_s.full_pipe = {s.full_pipe[0], level == (DEPTH_C + ft_c)};

        // Level flags; fall-through shifts every threshold up by the output register.
        next_s.ae_n = level > (dcf_widen(s.empty_off) + ft_c);
        next_s.hf_n = !(level > (HALF_C + ft_c));
        next_s.af_n = !(level >= (DEPTH_C + ft_c - dcf_widen(s.full_off)));

        // Map: 0 empty offset, 4 full offset, 8 status, C level.
        // Writes to status, level or holes are acked and dropped.
        // Wishbone slave: one wait state, ack for one cycle, unmapped reads as zero.
        access      = wb_cyc_i && wb_stb_i && !s.ack;
        next_s.ack  = access;
        next_s.rdata = '0;
        if (access && wb_we_i) begin
            // Offsets take a new value at any time after reset, whatever the method.
            unique case (wb_adr_i)
                DCF_ADDR_EMPTY_OFF: begin
                    merged           = dcf_merge(32'(s.empty_off), wb_dat_i, wb_sel_i);
                    next_s.empty_off = merged[OFF_W-1:0];
                end
                DCF_ADDR_FULL_OFF: begin
                    merged          = dcf_merge(32'(s.full_off), wb_dat_i, wb_sel_i);
                    next_s.full_off = merged[OFF_W-1:0];
                end
                default: begin
                end
            endcase
        end else if (access) begin
            unique case (wb_adr_i)
                // Offsets cannot be read back while serial loading is selected.
                DCF_ADDR_EMPTY_OFF: begin
                    next_s.rdata = s.serial_load ? 32'h0000_0000 : 32'(s.empty_off);
                end
                DCF_ADDR_FULL_OFF: begin
                    next_s.rdata = s.serial_load ? 32'h0000_0000 : 32'(s.full_off);
                end
                DCF_ADDR_STATUS: begin
                    next_s.rdata[DCF_ST_EMPTY_PIN] = empty_flag_n;
                    next_s.rdata[DCF_ST_FULL_PIN]  = full_flag_n;
                    next_s.rdata[DCF_ST_AE_N]      = s.ae_n;
                    next_s.rdata[DCF_ST_HF_N]      = s.hf_n;
                    next_s.rdata[DCF_ST_AF_N]      = s.af_n;
                    next_s.rdata[DCF_ST_FT_MODE]   = ft;
                    next_s.rdata[DCF_ST_SERIAL]    = s.serial_load;
                end
                DCF_ADDR_LEVEL: begin
                    next_s.rdata = 32'(level);
                end
                default: begin
                end
            endcase
        end

        // Straps must stay steady for three reset edges: two to cross, one to latch.
        // Master reset empties the buffer and latches both straps from the synchronised pins.
        if (!rst_b) begin
            next_s           = '0;
            next_s.mode_sync = {s.mode_sync[0], mode_select_serial_in};
            next_s.load_sync = {s.load_sync[0], offset_load_n};
            next_s.mode      = s.mode_sync[DCF_SYNC_STAGES-1] ? DCF_MODE_FALL_THROUGH
                                                              : DCF_MODE_STANDARD;
            next_s.serial_load = s.load_sync[DCF_SYNC_STAGES-1];
            if (s.load_sync[DCF_SYNC_STAGES-1]) begin
                next_s.empty_off = DCF_OFF_SERIAL_DEF[OFF_W-1:0];
                next_s.full_off  = DCF_OFF_SERIAL_DEF[OFF_W-1:0];
            end else begin
                next_s.empty_off = DCF_OFF_PARALLEL_DEF[OFF_W-1:0];
                next_s.full_off  = DCF_OFF_PARALLEL_DEF[OFF_W-1:0];
            end

            // An empty buffer reads high on half-full and almost-full.
            next_s.hf_n = 1'b1;
            next_s.af_n = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // State register.
    // Reset is folded into the next-state logic above.
    always_ff @(posedge clk) begin
        s <= next_s;
    end

    // Storage array; kept outside the state struct because it is far too wide to pack.
    // Writes are held off during reset so a stray enable cannot land.
    always_ff @(posedge clk) begin
        if (rst_b && wr_ok) begin
            mem[s.wr_ptr] <= data_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Pins. In standard mode the flags follow the two-stage pipes; in fall-through the
    // output-ready pin follows the output register, which is loaded on the third edge.
    // Counting the write edge as 0: the count is set at 0, the
    // standard empty pin rises at 2, fall-through loads data_out at 3.
    assign empty_flag_n        = (s.mode == DCF_MODE_FALL_THROUGH) ? !s.out_valid
                                 : s.visible[DCF_SYNC_STAGES-1];
    assign full_flag_n         = (s.mode == DCF_MODE_FALL_THROUGH) ? s.full_pipe[DCF_SYNC_STAGES-1]
                                 : !s.full_pipe[DCF_SYNC_STAGES-1];

    // Level flags come straight from their registers.
    assign almost_empty_flag_n = s.ae_n;
    assign almost_full_flag_n  = s.af_n;
    assign half_full_flag_n    = s.hf_n;

    // Mode, data and bus reply.
    assign fall_through_mode   = (s.mode == DCF_MODE_FALL_THROUGH);
    assign data_out            = s.data_out;
    assign wb_dat_o            = s.rdata;
    assign wb_ack_o            = s.ack;

endmodule

// file: tb/dcf_checker.sv
`timescale 1ns/1ns
module dcf_checker
    import dcf_pkg::*;
#(
    parameter int DEPTH = DCF_DEPTH_DEF,
    parameter int WIDTH = DCF_WIDTH_DEF
) (
    input wire logic             clk,                 // System clock.
    input wire logic             rst_b,               // Reset, active low.
    input wire logic             wb_cyc_i,            // Bus cycle.
    input wire logic             wb_stb_i,            // Bus strobe.
    input wire logic [31:0]      wb_dat_o,            // Bus read data.
    input wire logic             wb_ack_o,            // Bus acknowledge.
    input wire logic             write_en_n,          // Write enable.
    input wire logic             read_en_n,           // Read enable.
    input wire logic [WIDTH-1:0] data_out,            // Output word.
    input wire logic             empty_flag_n,        // Empty or output-ready.
    input wire logic             full_flag_n,         // Full or input-ready.
    input wire logic             almost_full_flag_n,  // Almost-full flag.
    input wire logic             half_full_flag_n,    // Half-full flag.
    input wire logic             fall_through_mode    // Timing mode.
);
    // All checks share the one clock and are quiet while reset is held.
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    // A bus request that has not yet been answered.
    sequence bus_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence

    ////////////////////////////////////////////////////////////////////////////////
    // The slave answers one cycle after the request and never holds ack longer.
    chk_ack_delay: assert property (bus_req |=> wb_ack_o)
        else $error("Bus request not answered after one cycle.");
    chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("Acknowledge held for more than one cycle.");
    chk_dat_quiet: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("Read data not zero outside acknowledge.");

    ////////////////////////////////////////////////////////////////////////////////
    // The mode only moves while reset is applied, so strap changes later are harmless.
    chk_mode_held: assert property ($past(rst_b) |-> $stable(fall_through_mode))
        else $error("Timing mode changed outside reset.");
    // A full buffer must already show the almost-full and half-full levels.
    chk_full_partials: assert property ((fall_through_mode ? full_flag_n : !full_flag_n)
        |-> !almost_full_flag_n && !half_full_flag_n) else $error("Full without partial flags.");
    // The empty flag is first seen high three edges after the write into an empty buffer.
    chk_empty_lag: assert property (!fall_through_mode && $rose(empty_flag_n)
        |-> !$past(write_en_n, 3)) else $error("Empty flag rose without a write three edges back.");
    // Reads of an empty buffer must leave the output word alone.
    chk_std_empty_read: assert property (!fall_through_mode && !empty_flag_n && !read_en_n
        |=> $stable(data_out)) else $error("Read taken while empty in standard mode.");
    chk_ft_empty_read: assert property (fall_through_mode && empty_flag_n && !read_en_n
        |=> $stable(data_out) || !empty_flag_n) else $error("Read taken while empty in fall-through mode.");
endmodule

bind dcf_fifo dcf_checker #(.DEPTH(DEPTH), .WIDTH(WIDTH)) u_chk (.clk(clk), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .write_en_n(write_en_n), .read_en_n(read_en_n),
    .data_out(data_out), .empty_flag_n(empty_flag_n), .full_flag_n(full_flag_n),
    .almost_full_flag_n(almost_full_flag_n), .half_full_flag_n(half_full_flag_n),
    .fall_through_mode(fall_through_mode));

// file: tb/dcf_partner.sv
`timescale 1ns/1ns
module dcf_partner
    import dcf_pkg::*;
#(
    parameter int               WIDTH = DCF_WIDTH_DEF,
    parameter logic [WIDTH-1:0] BASE  = '0
) (
    input  wire logic             clk,               // System clock.
    input  wire logic             rst_b,             // Reset, active low.
    input  wire logic             wr_req,            // One write per cycle while high.
    input  wire logic             rd_req,            // One read per cycle while high.
    output logic                  write_en_n = 1'b1, // Buffer write enable.
    output logic      [WIDTH-1:0] data_in    = '0,   // Buffer input word.
    output logic                  read_en_n  = 1'b1  // Buffer read enable.
);
    logic [WIDTH-1:0] wr_cnt;

    // Writer sends a running count so every word is distinct; idle data is inverted so
    // that a sample taken one edge late cannot match the word just written.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            write_en_n <= 1'b1;
            read_en_n  <= 1'b1;
            wr_cnt     <= BASE;
        end else begin
            write_en_n <= !wr_req;
            read_en_n  <= !rd_req;
            data_in    <= wr_req ? wr_cnt : ~data_in;
            wr_cnt     <= wr_req ? wr_cnt + 1'b1 : wr_cnt;
        end
    end
endmodule

// file: tb/dcf_fifo_tb.sv
`timescale 1ns/1ns
module dcf_fifo_tb
    import dcf_pkg::*;
;
    localparam int          D     = 2048;
    localparam int          D2    = D / 2;
    localparam logic [17:0] DBASE = 18'h00100;
    logic        clk = 1'b0, rst_b = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, wr_req = 1'b0, rd_req = 1'b0;
    logic        mode_pin = 1'b0, load_pin = 1'b0, ft, ld, ack, write_en_n, read_en_n;
    logic        ef_n, ff_n, ae_n, af_n, hf_n;
    logic [3:0]  adr = 4'h0;
    logic [31:0] wdat = 32'h0, rdat, q;
    logic [17:0] data_in, data_out;
    int          num_errors = 0, total_checks = 0, lvl, rdn, n, m, t;
    int          fill[7], drain[6];

    // Free-running 100 MHz clock.
    always #5 clk = ~clk;

    dcf_fifo #(.DEPTH(D)) dut (.clk(clk), .rst_b(rst_b), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .write_en_n(write_en_n), .data_in(data_in), .read_en_n(read_en_n), .data_out(data_out),
        .mode_select_serial_in(mode_pin), .offset_load_n(load_pin), .empty_flag_n(ef_n), .full_flag_n(ff_n),
        .almost_empty_flag_n(ae_n), .almost_full_flag_n(af_n), .half_full_flag_n(hf_n), .fall_through_mode());
    dcf_partner #(.WIDTH(18), .BASE(DBASE)) u_partner (.clk(clk), .rst_b(rst_b), .wr_req(wr_req),
        .rd_req(rd_req), .write_en_n(write_en_n), .data_in(data_in), .read_en_n(read_en_n));

    ////////////////////////////////////////////////////////////////////////////////
    // Comparison, verdict and bus access.
    task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic test_done();
        $display("checks=%0d errors=%0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Classic single cycle; entered just after a rising edge, leaves one idle cycle behind.
    task automatic wb_rw(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
        int k;
        k = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        @(posedge clk);
        while (ack !== 1'b1 && k < 20) begin
            @(posedge clk);
            k++;
        end
        r = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        if (k == 20) begin
            num_errors++;
            test_done();
        end
        @(posedge clk);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Buffer traffic and the expected picture at each level.
    task automatic pump(input logic w, input int k);
        wr_req <= w;
        rd_req <= !w;
        repeat (k) @(posedge clk);
        wr_req <= 1'b0;
        rd_req <= 1'b0;
    endtask

    // Flags in status order {af, hf, ae, full pin, empty pin}; f counts the output register.
    function automatic logic [4:0] exp_flags(input int l);
        int f;
        f = ft ? 1 : 0;
        return {l < D + f - m, l <= D2 + f, l > n + f, ft ? l > D : l < D, ft ? l == 0 : l != 0};
    endfunction

    // Six idle edges cover the slowest flag path before anything is compared.
    task automatic settle_check();
        repeat (6) @(posedge clk);
        check_val({27'h0, af_n, hf_n, ae_n, ff_n, ef_n}, {27'h0, exp_flags(lvl)});
        wb_rw(1'b0, DCF_ADDR_STATUS, 32'h0, q);
        check_val(q, {25'h0, ld, ft, exp_flags(lvl)});
        wb_rw(1'b0, DCF_ADDR_LEVEL, 32'h0, q);
        check_val(q, lvl);
        check_val(32'(data_out), (ft && lvl > 0) ? DBASE + rdn : (rdn > 0 ? DBASE + rdn - 1 : 0));
    endtask

    task automatic move_to(input int target);
        if (target > lvl) begin
            pump(1'b1, target - lvl);
        end else if (target < lvl) begin
            pump(1'b0, lvl - target);
            rdn += lvl - target;
        end
        lvl = target;
        settle_check();
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Standard mode with parallel defaults, then fall-through with serial defaults.
    initial begin
        @(posedge clk);
        for (int p = 0; p < 2; p++) begin
            ft = p[0];
            ld = p[0];
            rst_b <= 1'b0;
            mode_pin <= ft;
            load_pin <= ld;
            repeat (16) @(posedge clk);
            rst_b <= 1'b1;
            @(posedge clk);
            mode_pin <= !ft;
            lvl = 0;
            rdn = 0;
            n = ld ? 1023 : 127;
            wb_rw(1'b0, DCF_ADDR_EMPTY_OFF, 32'h0, q);
            check_val(q, ld ? 32'h0 : 32'h7F);
            if (!ld) begin
                wb_rw(1'b1, DCF_ADDR_EMPTY_OFF, 32'hC8, q);
                n = 200;
            end
            wb_rw(1'b1, DCF_ADDR_FULL_OFF, 32'h64, q);
            m = 100;
            wb_rw(1'b0, DCF_ADDR_FULL_OFF, 32'h0, q);
            check_val(q, ld ? 32'h0 : 32'h64);
            wb_rw(1'b1, DCF_ADDR_STATUS, 32'hFFFFFFFF, q);
            // The first word into an empty buffer shows after the documented latency.
            pump(1'b1, 1);
            t = 0;
            while (ef_n !== !ft && t < 20) begin
                @(posedge clk);
                t++;
            end
            check_val(t, ft ? DCF_FT_LATENCY + 2 : DCF_SYNC_STAGES + 2);
            if (t == 20) test_done();
            lvl = 1;
            fill = '{n + p, n + 1 + p, D2 + p, D2 + 1 + p, D + p - m - 1, D + p - m, D + p};
            foreach (fill[i]) move_to(fill[i]);
            pump(1'b1, 1);
            settle_check();
            drain = '{D + p - 1, D + p - m - 1, D2 + p, n + 1 + p, n + p, 0};
            foreach (drain[i]) move_to(drain[i]);
            pump(1'b0, 1);
            settle_check();
        end
        test_done();
    end
endmodule
